// File: hdl/timer_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_SYSTEM_CONFIG 8'h00
`define OFF_TIMER_MODE    8'h04
`define OFF_RUN_FLAG      8'h08
`define OFF_COUNT0        8'h0C
`define OFF_COUNT1        8'h10
`define OFF_RELOAD0       8'h14
`define OFF_RELOAD1       8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PRESCALE_LSB      2
`define RUN_LSB           0
`define FLAG_LSB          4
`define GATE_BIT          3
`define SRC_BIT           2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SYSTEM_CONFIG_RST 8'h00
`define TIMER_MODE_RST    8'h00

// ----------------------------------------------------------------
// Timing: prescaler masks and pin sample period in oscillator cycles
// ----------------------------------------------------------------
`define DIV4_MASK         6'h03
`define DIV16_MASK        6'h0F
`define DIV64_MASK        6'h3F
`define SAMPLE_PERIOD     2

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// File: hdl/timer_pkg.sv
// Types shared by the timer/counter design
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_RELOAD16 = 2'h0,
    MODE_FREE16   = 2'h1,
    MODE_RELOAD8  = 2'h2,
    MODE_SPLIT8   = 2'h3
  } mode_type;

  typedef enum logic [1:0] {
    PRESCALE_DIV4  = 2'h0,
    PRESCALE_DIV16 = 2'h1,
    PRESCALE_DIV64 = 2'h2,
    PRESCALE_RSVD  = 2'h3
  } prescale_type;

endpackage

// File: hdl/tick_if.sv
// Carrier between the register/count core and the tick generator
`timescale 1ns/1ps
interface tick_if;
  import timer_pkg::*;
  prescale_type prescale_sel;
  logic [1:0]   count_input_pin;
  logic         timer_tick;
  logic [1:0]   count_edge;

  modport gen  (input prescale_sel, input count_input_pin,
                output timer_tick, output count_edge);
  modport core (output prescale_sel, output count_input_pin,
                input timer_tick, input count_edge);
endinterface

// File: hdl/timer_tick_gen.sv
// Shared prescaler and sampled falling-edge detect on count inputs
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_tick_gen
  import timer_pkg::*;
#(
  parameter int PRESCALE_W = 6,
  parameter int NUM_PINS   = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  tick_if.gen      tk
);

  generate
    if (PRESCALE_W < 6 || NUM_PINS != 2) begin : g_bad
      $error("timer_tick_gen: unsupported parameters");
    end
  endgenerate

  logic [5:0]          div_reg;
  logic [5:0]          mask;
  logic                tick_reg;
  logic                phase_reg;
  logic [NUM_PINS-1:0] sample_reg;
  logic [NUM_PINS-1:0] edge_reg;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Divider select; the reserved code falls back to divide-by-4
  always_comb begin
    case (tk.prescale_sel)
      PRESCALE_DIV16: mask = `DIV16_MASK;
      PRESCALE_DIV64: mask = `DIV64_MASK;
      default:        mask = `DIV4_MASK;
    endcase
  end

  // One free-running divider feeds every channel in timer mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_reg + 6'h01;
      tick_reg <= ((div_reg & mask) == mask);
    end
  end

  // ----------------------------------------------------------------
  // Count input sampling
  // ----------------------------------------------------------------
  // Sample phase toggles so each pin is looked at every second cycle
  always_ff @(posedge ref_clk) begin
    if (reset)
      phase_reg <= 1'b0;
    else
      phase_reg <= ~phase_reg;
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // High sample followed by low sample is one counted edge
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        sample_reg[i] <= 1'b0;
        edge_reg[i]   <= 1'b0;
      end else begin
        edge_reg[i] <= phase_reg & sample_reg[i]
                       & ~tk.count_input_pin[i];
        if (phase_reg)
          sample_reg[i] <= tk.count_input_pin[i];
      end
    end

    a_edge_on_phase : assert property (@(posedge ref_clk) disable iff (reset)
      edge_reg[i] |-> $past(phase_reg) && !phase_reg)
      else $error("count edge outside sample slot");
    a_edge_is_fall : assert property (@(posedge ref_clk) disable iff (reset)
      edge_reg[i] |-> !sample_reg[i] && $past(sample_reg[i]))
      else $error("count edge without high to low");
  end

  a_tick_spacing : assert property (@(posedge ref_clk) disable iff (reset)
    tick_reg |=> !tick_reg [*3])
    else $error("timer tick faster than divide-by-4");

  assign tk.timer_tick = tick_reg;
  assign tk.count_edge = edge_reg;

endmodule

// File: hdl/dual_timer_counter.sv
// Dual 16-bit timer/counter with shared prescaler, AXI4-Lite registers
//
// Operation
// - Prescale code 00 gives osc/4, 01 osc/16, 10 osc/64; 11 reserved.
// - One prescaler rate drives every channel in timer mode.
// - Counter mode counts each high-to-low edge on the count pin.
// - Count pins are sampled every 2 cycles; edges seen within 4.
// - Source bit clear selects prescaled tick, set selects count pin.
// - Gate set: count only while run bit set and interrupt pin high.
// - Mode 00 reload16, 01 free16, 10 reload8, 11 split (ch0 only).
// - Mode register: ch1 upper nibble, ch0 lower; gate,src,mode; reset 0.
// - Channels count up and count is readable while running.
// - Two 16-bit channels, coupled only in ch0 mode 3, share the central time base.
// - Prescale select sits in config bits 3:2, resets to divide-by-4.
// - Reload16 high-byte overflow sets flag, reloads both bytes.
// - Reload8 low-byte overflow sets flag, reloads low, keeps high.
// - Channel 1 in mode 3 holds its count as if stopped.
// - Ch0 mode 3: high byte times on ch1 run bit and ch1 flag.
`timescale 1ns/1ps
`include "timer_regs.svh"
module dual_timer_counter
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        count_input_pin,
  input  wire logic [1:0]        ext_int_pin,
  output logic [1:0]             overflow_flag
);

  generate
    if (ADDR_W < 8) begin : g_bad
      $error("dual_timer_counter: ADDR_W too small");
    end
  endgenerate

  logic [7:0]        system_config_reg;
  logic [7:0]        timer_mode_control_reg;
  logic [1:0]        run_ctl_reg;
  logic [1:0]        flag_reg;
  logic [15:0]       count_reg [2];
  logic [15:0]       count_next [2];
  logic [15:0]       reload_reg [2];
  logic [1:0]        ovf;
  logic [1:0]        flag_set;
  logic              ovf_hi;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_fire;
  logic              wr_known;
  logic [1:0]        count_wr;
  logic [31:0]       rd_word;
  logic              rd_known;

  tick_if tk ();

  timer_tick_gen #(
    .PRESCALE_W (6),
    .NUM_PINS   (2)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tk      (tk.gen)
  );

  assign tk.prescale_sel    =
    prescale_type'(system_config_reg[`PRESCALE_LSB +: 2]);
  assign tk.count_input_pin = count_input_pin;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are caught in either order; write once both held
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_reg   <= 1'b0;
      end else begin
        s_axi_awready <= ~aw_held_reg;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_reg   <= 1'b0;
      end else begin
        s_axi_wready <= ~w_held_reg;
      end
    end
  end

  // Address decode for writes
  always_comb begin
    case (awaddr_reg[7:0])
      `OFF_SYSTEM_CONFIG, `OFF_TIMER_MODE, `OFF_RUN_FLAG,
      `OFF_COUNT0, `OFF_COUNT1, `OFF_RELOAD0, `OFF_RELOAD1:
        wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Write response, unmapped addresses answer with an error
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Prescale field, mode nibbles and run bits on byte lane 0; reload bytes on lanes 0 and 1
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      system_config_reg      <= `SYSTEM_CONFIG_RST;
      timer_mode_control_reg <= `TIMER_MODE_RST;
      run_ctl_reg            <= 2'h0;
      reload_reg[0]          <= 16'h0000;
      reload_reg[1]          <= 16'h0000;
    end else if (wr_fire) begin
      if (awaddr_reg[7:0] == `OFF_SYSTEM_CONFIG && wstrb_reg[0])
        system_config_reg <= {4'h0, wdata_reg[3:2], 2'h0};
      if (awaddr_reg[7:0] == `OFF_TIMER_MODE && wstrb_reg[0])
        timer_mode_control_reg <= wdata_reg[7:0];
      if (awaddr_reg[7:0] == `OFF_RUN_FLAG && wstrb_reg[0])
        run_ctl_reg <= wdata_reg[`RUN_LSB +: 2];
      for (int n = 0; n < 2; n++) begin
        if (awaddr_reg[7:0] == (`OFF_RELOAD0 + 8'(4 * n))) begin
          if (wstrb_reg[0])
            reload_reg[n][7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1])
            reload_reg[n][15:8] <= wdata_reg[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Count channels
  // ----------------------------------------------------------------
  for (genvar n = 0; n < 2; n++) begin : g_ch
    logic     gate;
    logic     src;
    mode_type mode;
    logic     en;
    logic     inc;
    logic     hi_ovf;

    assign gate = timer_mode_control_reg[4*n + `GATE_BIT];
    assign src  = timer_mode_control_reg[4*n + `SRC_BIT];
    assign mode = mode_type'(timer_mode_control_reg[4*n +: 2]);
    assign en   = run_ctl_reg[n] & (~gate | ext_int_pin[n]);
    assign inc  = en & (src ? tk.count_edge[n]
                            : tk.timer_tick);
    assign count_wr[n] = wr_fire & (awaddr_reg[7:0] ==
                         (`OFF_COUNT0 + 8'(4 * n)));

    // Next count and overflow per mode, always counting upward
    always_comb begin
      count_next[n] = count_reg[n];
      ovf[n]        = 1'b0;
      hi_ovf        = 1'b0;
      case (mode)
        MODE_RELOAD16, MODE_FREE16: if (inc) begin
          ovf[n] = (count_reg[n] == 16'hFFFF);
          if (ovf[n] && mode == MODE_RELOAD16)
            count_next[n] = reload_reg[n];
          else
            count_next[n] = count_reg[n] + 16'h0001;
        end
        MODE_RELOAD8: if (inc) begin
          ovf[n] = (count_reg[n][7:0] == 8'hFF);
          count_next[n][7:0] = ovf[n] ? reload_reg[n][7:0]
                                      : count_reg[n][7:0] + 8'h01;
        end
        default: if (n == 0) begin // ch1 in mode 3 holds
          if (inc) begin
            ovf[n] = (count_reg[n][7:0] == 8'hFF);
            count_next[n][7:0] = count_reg[n][7:0] + 8'h01;
          end
          if (run_ctl_reg[1] && tk.timer_tick) begin
            hi_ovf = (count_reg[n][15:8] == 8'hFF);
            count_next[n][15:8] = count_reg[n][15:8] + 8'h01;
          end
        end
      endcase
    end

    if (n == 0) begin : g_hi
      assign ovf_hi = hi_ovf;
    end

    // Software write of the count wins over counting in that cycle
    always_ff @(posedge ref_clk) begin
      if (reset)
        count_reg[n] <= 16'h0000;
      else if (count_wr[n]) begin
        count_reg[n][7:0]  <= wstrb_reg[0] ? wdata_reg[7:0]
                                           : count_next[n][7:0];
        count_reg[n][15:8] <= wstrb_reg[1] ? wdata_reg[15:8]
                                           : count_next[n][15:8];
      end else
        count_reg[n] <= count_next[n];
    end
  end

  // Ch1 flag belongs to the ch0 high byte while ch0 is split
  assign flag_set[0] = ovf[0];
  assign flag_set[1] = (g_ch[0].mode == MODE_SPLIT8) ? ovf_hi
                                                      : ovf[1];

  // Overflow flags: write one clears, a same-cycle overflow still sets
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_reg      <= 2'h0;
      overflow_flag <= 2'h0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (flag_set[n])
          flag_reg[n] <= 1'b1;
        else if (wr_fire && awaddr_reg[7:0] == `OFF_RUN_FLAG &&
                 wstrb_reg[0] && wdata_reg[`FLAG_LSB + n])
          flag_reg[n] <= 1'b0;
        overflow_flag[n] <= flag_set[n] | flag_reg[n];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Read mux, live counts visible at any time
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr[7:0])
      `OFF_SYSTEM_CONFIG: rd_word = {24'h0, system_config_reg};
      `OFF_TIMER_MODE:    rd_word = {24'h0, timer_mode_control_reg};
      `OFF_RUN_FLAG:      rd_word = {26'h0, flag_reg, 2'h0, run_ctl_reg};
      `OFF_COUNT0:        rd_word = {16'h0, count_reg[0]};
      `OFF_COUNT1:        rd_word = {16'h0, count_reg[1]};
      `OFF_RELOAD0:       rd_word = {16'h0, reload_reg[0]};
      `OFF_RELOAD1:       rd_word = {16'h0, reload_reg[1]};
      default: begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_reload_both : assert property (
    g_ch[0].mode == MODE_RELOAD16 && g_ch[0].inc && !count_wr[0]
    && count_reg[0] == 16'hFFFF
    |=> count_reg[0] == $past(reload_reg[0]) && flag_reg[0])
    else $error("reload16 did not reload or flag");
  a_reload8_high : assert property (
    g_ch[0].mode == MODE_RELOAD8 && !count_wr[0]
    |=> count_reg[0][15:8] == $past(count_reg[0][15:8]))
    else $error("reload8 changed the high byte");
  a_free_wrap : assert property (
    g_ch[0].mode == MODE_FREE16 && g_ch[0].inc && !count_wr[0]
    && count_reg[0] == 16'hFFFF |=> count_reg[0] == 16'h0000
    ##1 overflow_flag[0])
    else $error("free16 did not wrap to zero");
  a_count_up : assert property (
    g_ch[0].mode == MODE_FREE16 && g_ch[0].inc && !count_wr[0]
    |=> count_reg[0] == $past(count_reg[0]) + 16'h0001)
    else $error("count did not step up by one");
  a_ch1_hold : assert property (
    g_ch[1].mode == MODE_SPLIT8 && !count_wr[1]
    |=> $stable(count_reg[1]))
    else $error("channel 1 in mode 3 moved");
  a_gate_stop : assert property (
    g_ch[0].gate && !ext_int_pin[0] && g_ch[0].mode != MODE_SPLIT8
    && !count_wr[0] |=> $stable(count_reg[0]))
    else $error("gated channel counted with pin low");
  a_split_flag : assert property (
    g_ch[0].mode == MODE_SPLIT8 && run_ctl_reg[1] && tk.timer_tick
    && count_reg[0][15:8] == 8'hFF && !count_wr[0]
    |=> flag_reg[1] && count_reg[0][15:8] == 8'h00)
    else $error("split high byte overflow lost");
  a_tick_source : assert property (
    !g_ch[0].src && run_ctl_reg[0] && !g_ch[0].gate
    |-> g_ch[0].inc == tk.timer_tick)
    else $error("timer mode ignores the tick");
  a_bresp_hold : assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  c_reload16  : cover property (ovf[0] &&
                                g_ch[0].mode == MODE_RELOAD16);
  c_split     : cover property (ovf_hi && flag_set[1]);
  c_ext_count : cover property (g_ch[1].src && g_ch[1].inc);
  c_gated     : cover property (g_ch[0].gate && run_ctl_reg[0]
                                && !ext_int_pin[0]);

endmodule

// File: verif/pin_source.sv
// Model of the external count and gate pins facing the timer
`timescale 1ns/1ps
module pin_source (
  input  wire logic       ref_clk,
  output logic [1:0]      count_input_pin,
  output logic [1:0]      ext_int_pin
);
  // --------------------------------------------------------------
  // Idle levels: count inputs high, gates closed
  // --------------------------------------------------------------
  initial begin
    count_input_pin = 2'h3;
    ext_int_pin     = 2'h0;
  end

  // One falling edge per pulse, low held 3 clocks, high 4 before the next
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      count_input_pin[ch] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      count_input_pin[ch] <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // Gate levels change just after an edge
  task automatic gate(input logic [1:0] v);
    @(posedge ref_clk);
    ext_int_pin <= v;
  endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, d2;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  logic [1:0]  count_input_pin, ext_int_pin, overflow_flag;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          e;
  logic [7:0]  cfg [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  int          dv  [4] = '{4, 16, 64, 4};

  always #25 ref_clk = ~ref_clk;

  dual_timer_counter dut (
    .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .count_input_pin, .ext_int_pin,
    .overflow_flag
  );

  pin_source src (.ref_clk, .count_input_pin, .ext_int_pin);

  // --------------------------------------------------------------
  // Bus tasks and comparison
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    v  = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask

  // Channel 0 counting pin edges from a preset count and reload
  task automatic ev(input logic [7:0] m, input logic [15:0] c, rl,
                    input int n);
    wr(8'h04, 32'(m));
    wr(8'h14, 32'(rl));
    wr(8'h0C, 32'(c));
    wr(8'h08, 32'h31);
    src.pulse(0, n);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    wr(8'h04, 32'hA5);
    chk(32'(b), 32'h0);
    rdchk(8'h04, 32'hA5);
    wr(8'h04, 32'h00);
    // Table: prescale code beside its divider, both channels on ticks
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'(cfg[i]));
      rdchk(8'h00, 32'(cfg[i]));
      wr(8'h0C, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h08, 32'h3);
      repeat (256) @(posedge ref_clk);
      wr(8'h08, 32'h30);
      rd(8'h0C, d, r);
      rd(8'h10, d2, r);
      e = 256 / dv[i];
      chk(32'(d >= 32'(e) && d <= 32'(e + 3)), 32'h1);
      chk(d2, d);
    end
    ev(8'h04, 16'h0000, 16'h0000, 5);
    rdchk(8'h0C, 32'h5);
    chk(32'(overflow_flag), 32'h0);
    ev(8'h0C, 16'h0000, 16'h0000, 3);
    rdchk(8'h0C, 32'h0);
    src.gate(2'h1);
    ev(8'h0C, 16'h0000, 16'h0000, 2);
    rdchk(8'h0C, 32'h2);
    src.gate(2'h0);
    ev(8'h04, 16'hFFFE, 16'hFFF0, 3);
    rdchk(8'h0C, 32'hFFF1);
    rdchk(8'h08, 32'h11);
    chk(32'(overflow_flag), 32'h1);
    ev(8'h05, 16'hFFFF, 16'h0000, 2);
    rdchk(8'h0C, 32'h1);
    chk(32'(overflow_flag), 32'h1);
    ev(8'h06, 16'h12FF, 16'h0080, 2);
    rdchk(8'h0C, 32'h1281);
    // Split mode: low byte counts pin edges on channel 0 controls
    ev(8'h07, 16'h00FF, 16'h0000, 1);
    rdchk(8'h0C, 32'h0);
    chk(32'(overflow_flag), 32'h1);
    // Split mode: high byte ticks on ch1 run bit and sets ch1 flag
    wr(8'h0C, 32'hFF00);
    wr(8'h08, 32'h32);
    repeat (8) @(posedge ref_clk);
    chk(32'(overflow_flag), 32'h2);
    rd(8'h0C, d, r);
    chk(32'(d[7:0]), 32'h0);
    wr(8'h04, 32'h70);
    wr(8'h10, 32'h1234);
    wr(8'h08, 32'h2);
    src.pulse(1, 3);
    rdchk(8'h10, 32'h1234);
    rd(8'h1C, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'h2);
    wr(8'h1C, 32'hFF);
    chk(32'(b), 32'h2);
    // Reset in mid-run clears configuration and flags
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'(overflow_flag), 32'h0);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    tally_and_finish();
  end
endmodule
